// >>> rpi_ctrl.sv
/*
 * Per-receive-port interrupt enables, upper interrupt status and the
 * combined interrupt output. Register accesses arrive from the serial
 * target logic on the same clock as single-cycle strobes.
 * Assumes events, low-group flags and link status read strobes come from
 * device core logic on clk.
 */
`timescale 1ns/1ps
`include "rpi_consts.svh"

// Function
// - Port select steers accesses to one copy
// - High enable bit 2: encoding error interrupt
// - High enable bit 1: sequence error interrupt
// - High enable bit 0: frame CRC interrupt
// - Low enable bit 6: line length change
// - Low enable bit 5: line count change
// - Low enable bit 4: buffer overflow
// - Low enable bit 2: parity errors
// - Low enable bit 1: port valid change
// - Low enable bit 0: lock change
// - Status bit 2 cleared by second read
// - Status bit 1 cleared by first read
// - Status bit 0 cleared by first read
// - Reset zero; reserved high bits read zero
module rpi_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire rpi_pkg::rpi_req_t req,
    output logic [7:0] rdata,
    input wire rpi_pkg::rpi_hi_evt_t hi_evt,
    input wire rpi_pkg::rpi_port_bytes_t lo_flags,
    input wire logic link_status_first_rd,
    input wire logic link_status_second_rd,
    output rpi_pkg::rpi_port_bytes_t lo_enables,
    output logic irq
);

    // Register state and its next value
    rpi_pkg::rpi_state_t s_r;
    rpi_pkg::rpi_state_t s_nxt;
    // Selected port index, read by the decode and the checks
    logic [`RPI_SEL_W-1:0] sel;
    // Per-port enabled sources
    logic [`RPI_NPORT-1:0] hit;

    // Address match helper, used by both write and read decode
    function automatic logic is_ofs(input logic [7:0] a,
                                    input logic [7:0] ofs);
        is_ofs = (a == ofs);
    endfunction

    assign sel = s_r.sel_r;

    // Next state: register writes, status set and clear, read data
    always_comb begin
        s_nxt = s_r;
        // Port select write
        if (req.wr && is_ofs(req.addr, `RPI_PORT_SEL_OFS)) begin
            s_nxt.sel_r = req.wdata[`RPI_SEL_W-1:0];
        end
        for (int p = 0; p < `RPI_NPORT; p++) begin
            if (req.wr && sel == p[`RPI_SEL_W-1:0]) begin
                if (is_ofs(req.addr, `RPI_EN_HIGH_OFS)) begin
                    s_nxt.en_hi_r[p] = req.wdata & `RPI_HI_MASK;
                end
                if (is_ofs(req.addr, `RPI_EN_LOW_OFS)) begin
                    s_nxt.en_lo_r[p] = req.wdata & `RPI_LO_MASK;
                end
            end
            if (link_status_second_rd && sel == p[`RPI_SEL_W-1:0]) begin
                s_nxt.st_hi_r[p][`RPI_HI_CODE_BIT] = 1'b0;
            end
            if (link_status_first_rd && sel == p[`RPI_SEL_W-1:0]) begin
                s_nxt.st_hi_r[p][`RPI_HI_ORDER_BIT] = 1'b0;
                s_nxt.st_hi_r[p][`RPI_HI_CHECK_BIT] = 1'b0;
            end
            if (hi_evt.code[p]) begin
                s_nxt.st_hi_r[p][`RPI_HI_CODE_BIT] = 1'b1;
            end
            if (hi_evt.order[p]) begin
                s_nxt.st_hi_r[p][`RPI_HI_ORDER_BIT] = 1'b1;
            end
            if (hi_evt.check[p]) begin
                s_nxt.st_hi_r[p][`RPI_HI_CHECK_BIT] = 1'b1;
            end
        end
        // Read data for the selected port, zero when unmapped
        if (req.rd) begin
            if (is_ofs(req.addr, `RPI_PORT_SEL_OFS)) begin
                s_nxt.rdata_r = {{(8-`RPI_SEL_W){1'b0}}, s_r.sel_r};
            end else if (is_ofs(req.addr, `RPI_EN_HIGH_OFS)) begin
                s_nxt.rdata_r = s_r.en_hi_r[sel];
            end else if (is_ofs(req.addr, `RPI_EN_LOW_OFS)) begin
                s_nxt.rdata_r = s_r.en_lo_r[sel];
            end else if (is_ofs(req.addr, `RPI_ST_HIGH_OFS)) begin
                s_nxt.rdata_r = s_r.st_hi_r[sel];
            end else begin
                s_nxt.rdata_r = `RPI_REG_RST;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Per-port interrupt sources gated by enables
    generate
        for (genvar g = 0; g < `RPI_NPORT; g++) begin : g_hit
            assign hit[g] = |(s_r.en_hi_r[g] & s_r.st_hi_r[g]) |
                            |(s_r.en_lo_r[g] & lo_flags[g]
                              & `RPI_LO_MASK);
        end
    endgenerate

    assign irq = |hit;
    assign rdata = s_r.rdata_r;
    assign lo_enables = s_r.en_lo_r;

    // Checks for port 0 status, enables and the interrupt output

    code_sets_status_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        hi_evt.code[0] |=> s_r.st_hi_r[0][2])
        else $error("code fault flag not set");
    order_sets_status_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        hi_evt.order[0] |=> s_r.st_hi_r[0][1])
        else $error("order fault flag not set");
    check_sets_status_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        hi_evt.check[0] |=> s_r.st_hi_r[0][0])
        else $error("check fault flag not set");
    second_read_clears_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        link_status_second_rd && sel == 2'h0 && !hi_evt.code[0]
        |=> !s_r.st_hi_r[0][2])
        else $error("second read did not clear");
    first_read_clears_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        link_status_first_rd && sel == 2'h0 && !hi_evt.order[0]
        && !hi_evt.check[0] |=> s_r.st_hi_r[0][1:0] == 2'h0)
        else $error("first read did not clear");
    flag_holds_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.st_hi_r[0][2] && !link_status_second_rd
        |=> s_r.st_hi_r[0][2])
        else $error("code fault flag lost");
    order_holds_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.st_hi_r[0][1] && !link_status_first_rd
        |=> s_r.st_hi_r[0][1])
        else $error("order fault flag lost");
    select_steers_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        req.wr && req.addr == 8'hd8 && sel != 2'h0
        |=> $stable(s_r.en_hi_r[0]))
        else $error("write reached unselected port");
    write_lands_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        req.wr && req.addr == `RPI_EN_LOW_OFS && sel == 2'h0
        |=> s_r.en_lo_r[0] == ($past(req.wdata) & `RPI_LO_MASK))
        else $error("write missed selected port");
    reserved_zero_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        $past(req.rd) && ($past(req.addr) == 8'hd8
        || $past(req.addr) == 8'hda) |-> rdata[7:3] == 5'h00)
        else $error("reserved bits read nonzero");
    irq_follows_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.en_hi_r[0][2] && hi_evt.code[0]
        |=> irq || !s_r.en_hi_r[0][2])
        else $error("enabled code fault gave no interrupt");
    order_irq_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.en_hi_r[0][1] && hi_evt.order[0]
        |=> irq || !s_r.en_hi_r[0][1])
        else $error("enabled order fault gave no interrupt");
    check_irq_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.en_hi_r[0][0] && hi_evt.check[0]
        |=> irq || !s_r.en_hi_r[0][0])
        else $error("enabled check fault gave no interrupt");
    width_irq_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.en_lo_r[0][6] && lo_flags[0][6] |-> irq)
        else $error("enabled width change gave no interrupt");
    height_irq_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.en_lo_r[0][5] && lo_flags[0][5] |-> irq)
        else $error("enabled height change gave no interrupt");
    overflow_irq_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.en_lo_r[0][4] && lo_flags[0][4] |-> irq)
        else $error("enabled overflow gave no interrupt");
    parity_irq_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.en_lo_r[0][2] && lo_flags[0][2] |-> irq)
        else $error("enabled parity fault gave no interrupt");
    valid_irq_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.en_lo_r[0][1] && lo_flags[0][1] |-> irq)
        else $error("enabled valid change gave no interrupt");
    lock_irq_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_r.en_lo_r[0][0] && lo_flags[0][0] |-> irq)
        else $error("enabled lock change gave no interrupt");
    irq_masked_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        lo_flags == '0 && s_r.en_hi_r == '0 |-> !irq)
        else $error("interrupt without enabled source");

endmodule // rpi_ctrl

// >>> rpi_consts.svh
/*
 * Register offsets, field positions and reset values of the per-port
 * interrupt enable and status logic.
 * Assumes inclusion by the package and the design module only.
 */
`ifndef RPI_CONSTS_SVH
`define RPI_CONSTS_SVH

// Register offsets on the register access port
`define RPI_PORT_SEL_OFS 8'h4c
`define RPI_EN_HIGH_OFS 8'hd8
`define RPI_EN_LOW_OFS 8'hd9
`define RPI_ST_HIGH_OFS 8'hda

// Number of receive ports and width of the selector
`define RPI_NPORT 4
`define RPI_SEL_W 2

// High enable and status field positions
`define RPI_HI_CODE_BIT 2
`define RPI_HI_ORDER_BIT 1
`define RPI_HI_CHECK_BIT 0
`define RPI_HI_MASK 8'h07

// Low enable field positions
`define RPI_LO_WIDTH_BIT 6
`define RPI_LO_HEIGHT_BIT 5
`define RPI_LO_OVF_BIT 4
`define RPI_LO_PAR_BIT 2
`define RPI_LO_VALID_BIT 1
`define RPI_LO_LOCK_BIT 0
`define RPI_LO_MASK 8'h77

// Reset values
`define RPI_REG_RST 8'h00

`endif

// >>> rpi_pkg.sv
/*
 * Types shared by the per-port interrupt enable and status logic.
 * Assumes rpi_consts.svh is on the include path.
 */
`include "rpi_consts.svh"

package rpi_pkg;

    // Per-port bytes, one per receive port
    typedef logic [`RPI_NPORT-1:0][7:0] rpi_port_bytes_t;

    // Register access request from the serial target
    typedef struct packed {
        logic [7:0] addr; // Register offset
        logic [7:0] wdata; // Write data
        logic wr; // One-cycle write strobe
        logic rd; // One-cycle read strobe
    } rpi_req_t;

    // Error events of the high group, one bit per port each
    typedef struct packed {
        logic [`RPI_NPORT-1:0] code; // Link encoding error
        logic [`RPI_NPORT-1:0] order; // Control channel sequence error
        logic [`RPI_NPORT-1:0] check; // Control channel frame CRC error
    } rpi_hi_evt_t;

    // Whole state of the block
    typedef struct packed {
        logic [`RPI_SEL_W-1:0] sel_r; // Selected port
        rpi_port_bytes_t en_hi_r; // High enables per port
        rpi_port_bytes_t en_lo_r; // Low enables per port
        rpi_port_bytes_t st_hi_r; // High status per port
        logic [7:0] rdata_r; // Read data
    } rpi_state_t;

endpackage : rpi_pkg

// >>> rpi_host.sv
/* Host model: register master that reaches the block over its
   request port. Assumes one clock and strobes sampled on posedge. */
`timescale 1ns/1ps
module rpi_host (
    input wire logic clk,
    output rpi_pkg::rpi_req_t req,
    input wire logic [7:0] rdata
);
    // Idle request at time zero
    initial req = '0;

    // One-cycle strobe; read data taken after the following edge
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        // Released fields carry inverted leftovers, not stale values
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
        #1 q = rdata;
    endtask
endmodule // rpi_host

// >>> rx_port_interrupt_enable_status_bench.sv
/* Bench for the per-port interrupt enables and status.
   Assumes rpi_pkg compiled first and the host model alongside. */
`timescale 1ns/1ps
module rx_port_interrupt_enable_status_bench;
    logic clk, rst_b, rd1, rd2, irq; // rd1/rd2: link status reads
    rpi_pkg::rpi_req_t req;
    rpi_pkg::rpi_hi_evt_t hi_evt;
    rpi_pkg::rpi_port_bytes_t lo_flags, lo_enables;
    logic [7:0] rdata, q;
    logic [31:0] seed = 32'h0000ecfe; // Random state
    int err_count = 0, total_checks = 0;
    int m_hi[4], m_lo[4], m_st[4], m_sel; // Reference model
    int lo_bits[6] = '{6, 5, 4, 2, 1, 0};

    rpi_ctrl rpi_ctrl_inst (.clk(clk), .rst_b(rst_b), .req(req),
        .rdata(rdata), .hi_evt(hi_evt), .lo_flags(lo_flags),
        .link_status_first_rd(rd1), .link_status_second_rd(rd2),
        .lo_enables(lo_enables), .irq(irq));
    rpi_host rpi_host_inst (.clk(clk), .req(req), .rdata(rdata));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Model interrupt: any enabled flag on any port
    function automatic logic exp_irq();
        logic r;
        r = 1'b0;
        for (int p = 0; p < 4; p++)
            r |= |((m_st[p] & m_hi[p]) | (lo_flags[p] & m_lo[p]));
        return r;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic outs();
        #1;
        check({7'h00, irq}, {7'h00, exp_irq()});
        for (int p = 0; p < 4; p++)
            check(lo_enables[p], 8'(m_lo[p]));
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        rpi_host_inst.access(1'b1, a, d, q);
        if (a == 8'h4c) m_sel = d[1:0];
        if (a == 8'hd8) m_hi[m_sel] = d & 8'h07;
        if (a == 8'hd9) m_lo[m_sel] = d & 8'h77;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        rpi_host_inst.access(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask

    // Event pulse: b is 2 code, 1 order, 0 check
    task automatic pulse_evt(input int p, input int b);
        @(posedge clk);
        hi_evt[b * 4 + p] <= 1'b1;
        @(posedge clk);
        hi_evt <= '0;
        m_st[p] |= 1 << b;
    endtask

    // Link status read of the selected port
    task automatic clr(input logic second);
        @(posedge clk);
        if (second) rd2 <= 1'b1;
        else rd1 <= 1'b1;
        @(posedge clk);
        rd1 <= 1'b0;
        rd2 <= 1'b0;
        m_st[m_sel] &= second ? 'h3 : 'h4;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end

    initial begin
        rst_b = 1'b0;
        hi_evt = '0;
        lo_flags = '0;
        rd1 = 1'b0;
        rd2 = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 'hd8; a <= 'hda; a++) rreg(8'(a), 8'h00);
        rreg(8'h55, 8'h00);
        outs();
        $display("test reset done");
        // Random enables per port, reserved bits written high
        for (int p = 0; p < 4; p++) begin
            seed = xs(seed);
            wreg(8'h4c, 8'(p));
            wreg(8'hd8, seed[7:0] | 8'hf8);
            wreg(8'hd9, seed[15:8] | 8'h88);
        end
        wreg(8'h55, 8'hff);
        for (int p = 0; p < 4; p++) begin
            wreg(8'h4c, 8'(p));
            rreg(8'hd8, 8'(m_hi[p]));
            rreg(8'hd9, 8'(m_lo[p]));
            rreg(8'h4c, 8'(p));
            outs();
        end
        $display("test enables done");
        for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < 3; b++) begin
                seed = xs(seed);
                wreg(8'h4c, 8'(p));
                wreg(8'hd8, seed[7:0]);
                pulse_evt(p, b);
                outs();
                rreg(8'hda, 8'(m_st[p]));
                clr(b != 2);
                rreg(8'hda, 8'(m_st[p]));
                clr(b == 2);
                rreg(8'hda, 8'h00);
                outs();
            end
        end
        $display("test status done");
        for (int p = 0; p < 4; p++) begin
            foreach (lo_bits[i]) begin
                seed = xs(seed);
                wreg(8'h4c, 8'(p));
                wreg(8'hd9, 8'(1 << lo_bits[i]));
                @(posedge clk);
                lo_flags[p] <= 8'(1 << lo_bits[i]);
                @(posedge clk);
                outs();
                wreg(8'hd9, seed[7:0] & ~8'(1 << lo_bits[i]));
                outs();
                lo_flags[p] <= 8'h00;
            end
        end
        $display("test low group done");
        // Mid-run reset with a flag and enables still live
        pulse_evt(3, 2);
        rreg(8'hda, 8'(m_st[3]));
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        m_sel = 0;
        for (int p = 0; p < 4; p++) begin
            m_hi[p] = 0;
            m_lo[p] = 0;
            m_st[p] = 0;
        end
        outs();
        rreg(8'h4c, 8'h00);
        for (int p = 0; p < 4; p++) begin
            wreg(8'h4c, 8'(p));
            rreg(8'hd8, 8'h00);
            rreg(8'hd9, 8'h00);
            rreg(8'hda, 8'h00);
        end
        $display("test mid reset done");
        complete_run();
    end
endmodule // rx_port_interrupt_enable_status_bench
